// ### rls_lock_bank.sv
`timescale 1ns/1ps
// What this block does
// R1: an 8-bit write of DA to port F073 unlocks ports 1072 to FC72
// R2: any other value written to the key port relocks them
// R3: ports E072, E872 and E472 stay reachable whatever the lock state
// R4: locked status reads go to the AT bus, data undefined
// R5: toggle bit 15 inverts after each status read; here it inverts only on status reads made while unlocked
// R6: software reads status twice; toggle change means unlocked
// R7: status bits 11 to 8 show second DMA channel masks
// R8: status bits 7 to 4 show first DMA channel masks
// R9: status bit 3 shows parallel port direction control bit 5
// R10: status bits 14 to 12 and 2 to 0 unused, read zero
// R11: key port write-only, bits 15 to 8 ignored; status port read-only
// R12: three-digit ports decode A9..A0, four-digit ports all 16 bits
// R13: any access to a locked register goes to the AT bus
// R14: reset locks the bank and clears the toggle flag
module rls_lock_bank (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire rls_pkg::rls_io_req_type io_req_in,
  input  wire logic [3:0]            dma1_mask_in,
  input  wire logic [3:0]            dma2_mask_in,
  input  wire logic [7:0]            par_ctrl_in,
  output rls_pkg::rls_io_rsp_type    io_rsp_out,
  output logic                       unlocked_out,
  output logic                       lockable_sel_out
);

  logic                    locked_q;
  logic                    locked_d;
  logic                    sel_q;
  logic                    sel_d;
  logic                    key_hit;
  logic                    stat_hit;
  logic                    in_range;
  logic                    always_open;
  logic                    stat_read_ok;
  logic [15:0]             status_word;
  logic                    acc;
  logic                    key_wr;
  logic                    lock_hit;
  logic [15:0]             live_status;
  logic                    unl_d;
  logic                    unl_q;
  logic                    ack_d;
  logic                    ack_q;
  logic                    fwd_d;
  logic                    fwd_q;
  logic [15:0]             data_d;
  logic [15:0]             data_q;

  // what the current cycle's request turns out to be
  typedef enum {
    CLS_NONE,
    CLS_STATUS,
    CLS_STATUS_FWD,
    CLS_LOCKED_FWD,
    CLS_KEY
  } rls_cls_type;

  rls_cls_type             cls;

  // status flop gives the toggle value from before this read is answered
  rls_status_reg u_status (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .dma1_mask_in (dma1_mask_in),
    .dma2_mask_in (dma2_mask_in),
    .par_ctrl_in  (par_ctrl_in[rls_pkg::PAR_CTRL_DIR_BIT]),
    .read_done_in (stat_read_ok),
    .status_out   (status_word)
  );

  // port decode helpers; the same compares feed several paths
  function automatic logic is_access(
    input rls_pkg::rls_io_req_type req
  );
    return req.rd || req.wr;
  endfunction : is_access

  // four-digit port: every address bit takes part
  function automatic logic hits_key(
    input logic [15:0] addr
  );
    return rls_pkg::rls_full_match(addr, rls_pkg::KEY_PORT_ADDR);
  endfunction : hits_key

  function automatic logic hits_status(
    input logic [15:0] addr
  );
    return rls_pkg::rls_full_match(addr, rls_pkg::STATUS_PORT_ADDR);
  endfunction : hits_status

  // expanded-memory and shadow ports never lock
  function automatic logic hits_open(
    input logic [15:0] addr
  );
    logic hit;
    hit = rls_pkg::rls_full_match(addr, rls_pkg::EMS_LO_ADDR);
    hit = hit || rls_pkg::rls_full_match(addr, rls_pkg::EMS_HI_ADDR);
    hit = hit || rls_pkg::rls_full_match(addr, rls_pkg::SHADOW_ADDR);
    return hit;
  endfunction : hits_open

  // lockable ports all end in 72; other ports in the span stay open
  function automatic logic hits_lock_range(
    input logic [15:0] addr
  );
    logic above;
    logic below;
    logic suffix;
    above  = addr >= rls_pkg::LOCK_RANGE_LO;
    below  = addr <= rls_pkg::LOCK_RANGE_HI;
    suffix = addr[7:0] == rls_pkg::LOCK_RANGE_LO[7:0];
    return above && below && suffix;
  endfunction : hits_lock_range

  // only an 8-bit cycle counts as a key write
  function automatic logic is_key_write(
    input rls_pkg::rls_io_req_type req
  );
    return req.wr && req.byte8 && hits_key(req.addr);
  endfunction : is_key_write

  // upper byte of the key port carries nothing
  function automatic logic key_unlocks(
    input logic [15:0] wdata
  );
    return wdata[7:0] == rls_pkg::UNLOCK_KEY;
  endfunction : key_unlocks

  // unused bits come back as zero
  function automatic logic [15:0] pack_status(
    input logic       toggle,
    input logic [3:0] dma2,
    input logic [3:0] dma1,
    input logic       dir
  );
    logic [15:0] word;
    word                         = 16'h0000;
    word[rls_pkg::TOGGLE_BIT]    = toggle;
    word[rls_pkg::DMA2_LSB +: 4] = dma2;
    word[rls_pkg::DMA1_LSB +: 4] = dma1;
    word[rls_pkg::PAR_DIR_BIT]   = dir;
    return word;
  endfunction : pack_status

  // status port first, then locked ports, then the key port
  function automatic rls_cls_type classify(
    input rls_pkg::rls_io_req_type req,
    input logic                    locked,
    input logic                    stat,
    input logic                    key,
    input logic                    lockable
  );
    rls_cls_type kind;
    kind = CLS_NONE;
    if (req.rd && stat && !locked) begin
      kind = CLS_STATUS;
    end else if (req.rd && stat) begin
      kind = CLS_STATUS_FWD;
    end else if ((req.rd || req.wr) && lockable && locked && !key) begin
      kind = CLS_LOCKED_FWD;
    end else if (req.wr && key) begin
      kind = CLS_KEY;
    end
    return kind;
  endfunction : classify

  always_comb begin
    acc          = is_access(io_req_in);
    key_hit      = hits_key(io_req_in.addr); // R12
    stat_hit     = hits_status(io_req_in.addr); // R12
    in_range     = hits_lock_range(io_req_in.addr);
    always_open  = hits_open(io_req_in.addr); // R3
    lock_hit     = in_range && !always_open;
    key_wr       = is_key_write(io_req_in); // R11
    stat_read_ok = io_req_in.rd && stat_hit && !locked_q; // R4
    // toggle flop still holds the pre-read value; masks taken live
    live_status  = pack_status(status_word[rls_pkg::TOGGLE_BIT],
                               dma2_mask_in,
                               dma1_mask_in,
                               par_ctrl_in[rls_pkg::PAR_CTRL_DIR_BIT]);
  end

  always_comb begin
    cls = classify(io_req_in, locked_q, stat_hit,
                   key_hit, lock_hit); // R4 R13
  end

  always_comb begin
    locked_d = locked_q;
    // reads of the key port never change the lock
    if (key_wr) begin
      if (key_unlocks(io_req_in.wdata)) begin
        locked_d = 1'b0; // R1
      end else begin
        locked_d = 1'b1; // R2
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      locked_q <= rls_pkg::LOCKED_RESET; // R14
    end else begin
      locked_q <= locked_d;
    end
  end

  // flag follows the lock in the same cycle the lock changes
  always_comb begin
    unl_d = !locked_d;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      unl_q <= 1'b0; // R14
    end else begin
      unl_q <= unl_d;
    end
  end

  // answer strobe: one cycle, the cycle after the request
  always_comb begin
    ack_d = 1'b0;
    case (cls)
      CLS_STATUS: begin
        ack_d = 1'b1;
      end
      CLS_KEY: begin
        ack_d = 1'b1; // R11
      end
      default: begin
        ack_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // locked cycles fall through; the bus side supplies the data
  always_comb begin
    fwd_d = 1'b0;
    case (cls)
      CLS_STATUS_FWD: begin
        fwd_d = 1'b1; // R4
      end
      CLS_LOCKED_FWD: begin
        fwd_d = 1'b1; // R13
      end
      default: begin
        fwd_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= fwd_d;
    end
  end

  // data stays zero unless a status read is answered
  always_comb begin
    data_d = 16'h0000;
    case (cls)
      CLS_STATUS: begin
        data_d = live_status; // R5 R7 R8 R9 R10
      end
      default: begin
        data_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      data_q <= 16'h0000;
    end else begin
      data_q <= data_d;
    end
  end

  // other units gate their lockable registers on this select
  always_comb begin
    sel_d = acc && lock_hit && !locked_q; // R13
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_comb begin
    io_rsp_out           = '0;
    io_rsp_out.ack       = ack_q;
    io_rsp_out.to_at_bus = fwd_q;
    io_rsp_out.rdata     = data_q;
  end

  assign unlocked_out     = unl_q;
  assign lockable_sel_out = sel_q;

endmodule : rls_lock_bank

// ### rls_pkg.sv
package rls_pkg;

  localparam logic [15:0] KEY_PORT_ADDR    = 16'hF073;
  localparam logic [15:0] STATUS_PORT_ADDR = 16'hFC72;
  localparam logic [15:0] LOCK_RANGE_LO    = 16'h1072;
  localparam logic [15:0] LOCK_RANGE_HI    = 16'hFC72;
  localparam logic [15:0] EMS_LO_ADDR      = 16'hE072;
  localparam logic [15:0] EMS_HI_ADDR      = 16'hE872;
  localparam logic [15:0] SHADOW_ADDR      = 16'hE472;
  localparam logic [7:0]  UNLOCK_KEY       = 8'hDA;
  localparam logic [9:0]  SHORT_ADDR_MASK  = 10'h3FF;

  localparam int          TOGGLE_BIT       = 15;
  localparam int          DMA2_LSB         = 8;
  localparam int          DMA1_LSB         = 4;
  localparam int          PAR_DIR_BIT      = 3;
  localparam int          PAR_CTRL_DIR_BIT = 5;

  localparam logic        LOCKED_RESET     = 1'b1;
  localparam logic        TOGGLE_RESET     = 1'b0;

  // one host i/o cycle, valid for a single clock
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        byte8;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rls_io_req_type;

  // one answer, valid for a single clock
  typedef struct packed {
    logic        ack;
    logic        to_at_bus;
    logic [15:0] rdata;
  } rls_io_rsp_type;

  function automatic logic rls_full_match(input logic [15:0] a,
                                          input logic [15:0] b);
    return a == b;
  endfunction : rls_full_match

  // three-digit ports compare only the low ten address bits
  function automatic logic rls_short_match(input logic [15:0] a,
                                           input logic [9:0]  p);
    return (a[9:0] & SHORT_ADDR_MASK) == p;
  endfunction : rls_short_match

endpackage : rls_pkg

// ### rls_status_reg.sv
`timescale 1ns/1ps
module rls_status_reg (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [3:0]  dma1_mask_in,
  input  wire logic [3:0]  dma2_mask_in,
  input  wire logic        par_ctrl_in,
  input  wire logic        read_done_in,
  output logic      [15:0] status_out
);

  logic        toggle_q;
  logic        toggle_d;
  logic [15:0] word_d;
  logic [15:0] word_q;

  always_comb begin
    toggle_d = toggle_q;
    if (read_done_in) begin
      toggle_d = ~toggle_q; // R5
    end
    word_d = 16'h0000; // R10
    word_d[rls_pkg::TOGGLE_BIT]            = toggle_d;
    word_d[rls_pkg::DMA2_LSB +: 4]         = dma2_mask_in; // R7
    word_d[rls_pkg::DMA1_LSB +: 4]         = dma1_mask_in; // R8
    word_d[rls_pkg::PAR_DIR_BIT]           = par_ctrl_in;  // R9
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      toggle_q <= rls_pkg::TOGGLE_RESET; // R14
      word_q   <= 16'h0000;
    end else begin
      toggle_q <= toggle_d;
      word_q   <= word_d;
    end
  end

  assign status_out = word_q;

endmodule : rls_status_reg

// ### rls_lock_bank_checker.sv
`timescale 1ns/1ps
module rls_lock_bank_checker (
  input wire logic                    clk_in,
  input wire logic                    resetn_in,
  input wire rls_pkg::rls_io_req_type io_req_in,
  input wire logic [3:0]              dma1_mask_in,
  input wire logic [3:0]              dma2_mask_in,
  input wire logic [7:0]              par_ctrl_in,
  input wire rls_pkg::rls_io_rsp_type io_rsp_out,
  input wire logic                    unlocked_out,
  input wire logic                    lockable_sel_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire [15:0] a  = io_req_in.addr;
  wire [15:0] r  = io_rsp_out.rdata;
  wire [7:0]  wd = io_req_in.wdata[7:0];
  wire        ax = io_req_in.rd || io_req_in.wr;
  wire        kw = io_req_in.wr && io_req_in.byte8 && a == 16'hF073;
  wire        sr = io_req_in.rd && a == 16'hFC72;
  wire        ems = a == 16'hE072 || a == 16'hE872 || a == 16'hE472;
  wire        lk = ax && a[7:0] == 8'h72 && a >= 16'h1072
                   && a <= 16'hFC72 && !ems;
  property p_unlock; kw && wd == 8'hDA |=> unlocked_out; endproperty
  a_unlock: assert property (p_unlock) else $error("no unlock");
  property p_relock; kw && wd != 8'hDA |=> !unlocked_out; endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_ems; ax && ems |=> !io_rsp_out.to_at_bus; endproperty
  a_ems: assert property (p_ems) else $error("ems routed");
  property p_lockrd;
    sr && !unlocked_out |=> io_rsp_out.to_at_bus && !io_rsp_out.ack;
  endproperty
  a_lockrd: assert property (p_lockrd) else $error("locked read");
  property p_toggle;
    sr && unlocked_out ##2 sr && unlocked_out |=> r[15] != $past(r[15], 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_stat;
    sr && unlocked_out |=> io_rsp_out.ack && r[14:0] == {3'h0,
      $past(dma2_mask_in), $past(dma1_mask_in), $past(par_ctrl_in[5]), 3'h0};
  endproperty
  a_stat: assert property (p_stat) else $error("bad status");
  property p_lock; lk && !unlocked_out |=> io_rsp_out.to_at_bus; endproperty
  a_lock: assert property (p_lock) else $error("lock leak");
  property p_sel; lk && unlocked_out |=> lockable_sel_out; endproperty
  a_sel: assert property (p_sel) else $error("no select");
  property p_rst; disable iff (1'b0) !resetn_in |=> !unlocked_out; endproperty
  a_rst: assert property (p_rst) else $error("reset unlocked");
  c_unl: cover property (kw ##1 unlocked_out);
  c_stat: cover property (sr && unlocked_out);
  c_bus: cover property (io_rsp_out.to_at_bus);
endmodule : rls_lock_bank_checker
bind rls_lock_bank rls_lock_bank_checker chk (.clk_in, .resetn_in,
  .io_req_in, .dma1_mask_in, .dma2_mask_in, .par_ctrl_in, .io_rsp_out,
  .unlocked_out, .lockable_sel_out);

// ### rls_host_model.sv
`timescale 1ns/1ps
module rls_host_model (
  input  wire logic                    clk_in,
  input  wire rls_pkg::rls_io_rsp_type io_rsp_in,
  output rls_pkg::rls_io_req_type      io_req_out
);
  rls_pkg::rls_io_rsp_type rsp;
  initial io_req_out = '0;
  // idle bus shows inverted address and data, never the last value
  task automatic io(input logic r, w, b, input logic [15:0] a, d);
    @(posedge clk_in);
    io_req_out <= '{r, w, b, a, d};
    @(posedge clk_in);
    io_req_out <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    #1 rsp = io_rsp_in;
  endtask : io
endmodule : rls_host_model

// ### test_rls_lock_bank.sv
`timescale 1ns/1ps
`define CK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_rls_lock_bank;
  logic                    clk_in = 1'b0;
  logic                    resetn_in = 1'b0;
  logic [3:0]              dma1_mask_in = 4'hA;
  logic [3:0]              dma2_mask_in = 4'h5;
  logic [7:0]              par_ctrl_in = 8'h20;
  logic                    unlocked_out;
  logic [15:0]             t0;
  rls_pkg::rls_io_req_type io_req_in;
  rls_pkg::rls_io_rsp_type io_rsp_out;
  int                      n_errors = 0;
  int                      num_checks = 0;
  int                      cyc = 0;
  rls_lock_bank dut (.clk_in, .resetn_in, .io_req_in, .dma1_mask_in,
    .dma2_mask_in, .par_ctrl_in, .io_rsp_out, .unlocked_out,
    .lockable_sel_out());
  rls_host_model host (.clk_in, .io_rsp_in(io_rsp_out),
    .io_req_out(io_req_in));
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial forever #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    host.io(1, 0, 0, 16'hFC72, 0);
    `CK("lock rd", 3'b010, {host.rsp.ack, host.rsp.to_at_bus, unlocked_out})
    host.io(0, 1, 0, 16'hF073, 16'h00DA);
    `CK("half key", 1'b0, unlocked_out)
    host.io(0, 1, 1, 16'hF073, 16'hFFDA);
    `CK("unlock", 1'b1, unlocked_out)
    host.io(1, 0, 0, 16'hFC72, 0);
    t0 = host.rsp.rdata;
    host.io(1, 0, 0, 16'hFC72, 0);
    `CK("status", 16'h05A8, host.rsp.rdata & 16'h7FFF)
    `CK("toggle", ~t0[15], host.rsp.rdata[15])
    host.io(0, 1, 1, 16'h1872, 0);
    `CK("open port", 1'b0, host.rsp.to_at_bus)
    host.io(0, 1, 1, 16'hF073, 16'h00DB);
    `CK("relock", 1'b0, unlocked_out)
    host.io(0, 1, 1, 16'h1872, 0);
    `CK("lock port", 1'b1, host.rsp.to_at_bus)
    host.io(1, 0, 0, 16'hE872, 0);
    `CK("ems", 1'b0, host.rsp.to_at_bus)
    final_report();
  end
endmodule : test_rls_lock_bank
